// [logic/isr_regs.svh]
`ifndef ISR_REGS_SVH
`define ISR_REGS_SVH

// ----------------------------------------------------------------
// Standard event bits
// ----------------------------------------------------------------
`define ISR_SE_OPC_BIT      0
`define ISR_SE_QUERY_BIT    2
`define ISR_SE_DEVICE_BIT   3
`define ISR_SE_EXEC_BIT     4
`define ISR_SE_CMD_BIT      5
`define ISR_SE_USER_BIT     6
`define ISR_SE_PON_BIT      7
`define ISR_SE_USED_MASK    8'hFD
`define ISR_SE_LATCH_RESET  8'h80
`define ISR_SE_MASK_RESET   8'h00

// ----------------------------------------------------------------
// Operation status bits
// ----------------------------------------------------------------
`define ISR_OP_CAL_BIT      0
`define ISR_OP_MEAS_BIT     4
`define ISR_OP_TRIG_BIT     5
`define ISR_OP_INIT_BIT     10
`define ISR_OP_LOW_BIT      11
`define ISR_OP_HIGH_BIT     12
`define ISR_OP_USED_MASK    16'h1C31
`define ISR_OP_COND_RESET   16'h0000
`define ISR_OP_EVT_RESET    16'h0000

// ----------------------------------------------------------------
// Command codes on the command port
// ----------------------------------------------------------------
`define ISR_CMD_ESR_QUERY   4'h1
`define ISR_CMD_MASK_WRITE  4'h2
`define ISR_CMD_MASK_QUERY  4'h3
`define ISR_CMD_OPC         4'h4
`define ISR_CMD_COND_QUERY  4'h5
`define ISR_CMD_EVT_QUERY   4'h6
`define ISR_CMD_RESET       4'h7
`define ISR_CMD_PRESET      4'h8
`define ISR_CMD_OTHER       4'h9

// ----------------------------------------------------------------
// Error queue codes
// ----------------------------------------------------------------
`define ISR_CODE_CMD_ERR    16'hFF9C

`endif

// [logic/isr_pkg.sv]
package isr_pkg;

    // Decoded command strobes
    typedef struct packed {
        logic esrQuery;
        logic maskWrite;
        logic maskQuery;
        logic opc;
        logic condQuery;
        logic evtQuery;
        logic reset;
        logic preset;
        logic other;
        logic isQuery;
        logic illegal;
    } isr_dec_type;

    // Operation-complete wait states
    typedef enum logic [1:0] {
        OPC_IDLE = 2'b01,
        OPC_WAIT = 2'b10
    } isr_opc_type;

endpackage

// [logic/isr_link_if.sv]
`timescale 1ns/1ps
interface isr_link_if;
    import isr_pkg::*;

    // Decoded command
    isr_dec_type dec;
    // Operation status
    logic [15:0] cond;
    logic [15:0] evt;
    logic        evtClear;
    logic        initStart;

    modport decoder (output dec);
    modport oper    (input evtClear, input initStart, output cond, output evt);
    modport core    (input dec, input cond, input evt, output evtClear, output initStart);
endinterface

// [logic/isr_cmd_decode.sv]
`timescale 1ns/1ps
`include "isr_regs.svh"
module isr_cmd_decode (
    // Command port
    input  wire logic       cmdValid,
    input  wire logic [3:0] cmdOp,
    // Decoded strobes
    isr_link_if.decoder     link
);
    import isr_pkg::*;

    // Map one command code to its strobe set
    function automatic isr_dec_type decodeOp(input logic valid, input logic [3:0] op);
        isr_dec_type d;
        d = '0;
        if (valid) begin
            unique case (op)
                `ISR_CMD_ESR_QUERY:  d.esrQuery  = 1'b1;
                `ISR_CMD_MASK_WRITE: d.maskWrite = 1'b1;
                `ISR_CMD_MASK_QUERY: d.maskQuery = 1'b1;
                `ISR_CMD_OPC:        d.opc       = 1'b1;
                `ISR_CMD_COND_QUERY: d.condQuery = 1'b1;
                `ISR_CMD_EVT_QUERY:  d.evtQuery  = 1'b1;
                `ISR_CMD_RESET:      d.reset     = 1'b1;
                `ISR_CMD_PRESET:     d.preset    = 1'b1;
                `ISR_CMD_OTHER:      d.other     = 1'b1;
                default:             d.illegal   = 1'b1;
            endcase
            d.isQuery = d.esrQuery | d.maskQuery | d.condQuery | d.evtQuery;
        end
        return d;
    endfunction

    // Strobes follow the command port directly
    always_comb begin
        link.dec = decodeOp(cmdValid, cmdOp);
    end
endmodule

// [logic/isr_oper_status.sv]
`timescale 1ns/1ps
`include "isr_regs.svh"
module isr_oper_status (
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic resetn,
    // Sensor activity levels
    input  wire logic calibrating,
    input  wire logic measuring,
    input  wire logic waitTrigger,
    input  wire logic belowLimit,
    input  wire logic aboveLimit,
    input  wire logic sensorConnect,
    input  wire logic initDone,
    // Link to core
    isr_link_if.oper  link
);
    import isr_pkg::*;

    logic        initializing;
    logic        next_initializing;
    logic [15:0] cond;
    logic [15:0] next_cond;
    logic [15:0] evt;
    logic [15:0] next_evt;

    // Next values of the initializing flag, condition and event parts
    always_comb begin
        // Entry wins over done in the same cycle
        next_initializing = initializing;
        if (initDone) begin
            next_initializing = 1'b0;
        end
        if (sensorConnect || link.initStart) begin
            next_initializing = 1'b1;
        end
        next_cond = 16'h0000;
        next_cond[`ISR_OP_CAL_BIT]  = calibrating;
        next_cond[`ISR_OP_MEAS_BIT] = measuring;
        next_cond[`ISR_OP_TRIG_BIT] = waitTrigger;
        next_cond[`ISR_OP_INIT_BIT] = initializing;
        next_cond[`ISR_OP_LOW_BIT]  = belowLimit;
        next_cond[`ISR_OP_HIGH_BIT] = aboveLimit;
        next_cond = next_cond & `ISR_OP_USED_MASK;
        // Any edge of a condition bit is recorded; set wins over clear
        next_evt = link.evtClear ? 16'h0000 : evt;
        next_evt = next_evt | (next_cond ^ cond);
    end

    // Register the operation state; power-up starts initialization
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            initializing <= 1'b1;
            cond         <= `ISR_OP_COND_RESET;
            evt          <= `ISR_OP_EVT_RESET;
        end else begin
            initializing <= next_initializing;
            cond         <= next_cond;
            evt          <= next_evt;
        end
    end

    assign link.cond = cond;
    assign link.evt  = evt;
endmodule

// [logic/isr_status_event_regs.sv]
`timescale 1ns/1ps
`include "isr_regs.svh"
module isr_status_event_regs (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        resetn,
    // Command port from the remote controller
    input  wire logic        cmdValid,
    input  wire logic [3:0]  cmdOp,
    input  wire logic [7:0]  cmdData,
    input  wire logic        readReq,
    // Response to the remote controller
    output logic             rspPending,
    output logic             rspStrobe,
    output logic [15:0]      rspData,
    // Device events
    input  wire logic        execBusy,
    input  wire logic        deviceFault,
    input  wire logic [15:0] deviceCode,
    input  wire logic        execFault,
    input  wire logic [15:0] execCode,
    input  wire logic        manualSwitch,
    // Sensor activity levels
    input  wire logic        calibrating,
    input  wire logic        measuring,
    input  wire logic        waitTrigger,
    input  wire logic        belowLimit,
    input  wire logic        aboveLimit,
    input  wire logic        sensorConnect,
    input  wire logic        initDone,
    // Error queue push and summary
    output logic             errPush,
    output logic [15:0]      errCode,
    output logic             eventSummary,
    output logic             resetPulse
);
    import isr_pkg::*;

    // ----------------------------------------------------------------
    // Sub-blocks
    // ----------------------------------------------------------------

    isr_link_if link ();

    // Command decoder
    isr_cmd_decode u_decode (
        .cmdValid (cmdValid),
        .cmdOp    (cmdOp),
        .link     (link.decoder)
    );

    // Operation condition and event parts
    isr_oper_status u_oper (
        .core_clk      (core_clk),
        .resetn        (resetn),
        .calibrating   (calibrating),
        .measuring     (measuring),
        .waitTrigger   (waitTrigger),
        .belowLimit    (belowLimit),
        .aboveLimit    (aboveLimit),
        .sensorConnect (sensorConnect),
        .initDone      (initDone),
        .link          (link.oper)
    );

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------

    logic [7:0]  eventLatch;
    logic [7:0]  next_eventLatch;
    logic [7:0]  eventMask;
    logic [7:0]  next_eventMask;
    isr_opc_type opcState;
    isr_opc_type next_opcState;
    logic        next_rspPending;
    logic        next_rspStrobe;
    logic [15:0] next_rspData;
    logic        next_errPush;
    logic [15:0] next_errCode;
    logic        next_eventSummary;
    logic        next_resetPulse;
    logic [7:0]  eventSet;
    logic        esrClear;
    logic        queryError;

    // Clear and start requests toward the operation block
    assign link.evtClear  = link.dec.evtQuery;
    assign link.initStart = link.dec.reset | link.dec.preset;

    // ----------------------------------------------------------------
    // Operation-complete tracking
    // ----------------------------------------------------------------

    // Wait for earlier commands to drain before flagging completion
    always_comb begin
        next_opcState = opcState;
        eventSet      = 8'h00;
        unique case (opcState)
            OPC_IDLE: begin
                if (link.dec.opc) begin
                    if (execBusy) begin
                        next_opcState = OPC_WAIT;
                    end else begin
                        eventSet[`ISR_SE_OPC_BIT] = 1'b1;
                    end
                end
            end
            OPC_WAIT: begin
                if (!execBusy) begin
                    eventSet[`ISR_SE_OPC_BIT] = 1'b1;
                    next_opcState = OPC_IDLE;
                end
            end
            default: begin
                next_opcState = OPC_IDLE;
            end
        endcase
        // Read with nothing pending, or new command over unread data
        queryError = (readReq && !rspPending) || (cmdValid && rspPending);
        eventSet[`ISR_SE_QUERY_BIT]  = queryError;
        eventSet[`ISR_SE_DEVICE_BIT] = deviceFault;
        eventSet[`ISR_SE_EXEC_BIT]   = execFault;
        eventSet[`ISR_SE_CMD_BIT]    = link.dec.illegal;
        eventSet[`ISR_SE_USER_BIT]   = manualSwitch;
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            opcState <= OPC_IDLE;
        end else begin
            opcState <= next_opcState;
        end
    end

    // ----------------------------------------------------------------
    // Standard event latch and mask
    // ----------------------------------------------------------------

    // Latch accumulates events; a query clears it but a new set survives
    always_comb begin
        esrClear        = link.dec.esrQuery;
        next_eventLatch = esrClear ? 8'h00 : eventLatch;
        next_eventLatch = (next_eventLatch | eventSet) & `ISR_SE_USED_MASK;
        next_eventMask  = eventMask;
        if (link.dec.maskWrite) begin
            next_eventMask = cmdData & `ISR_SE_USED_MASK;
        end
        next_eventSummary = |(next_eventLatch & next_eventMask);
    end

    // Power-up event is the reset value of the latch
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            eventLatch   <= `ISR_SE_LATCH_RESET;
            eventMask    <= `ISR_SE_MASK_RESET;
            eventSummary <= 1'b0;
        end else begin
            eventLatch   <= next_eventLatch;
            eventMask    <= next_eventMask;
            eventSummary <= next_eventSummary;
        end
    end

    // ----------------------------------------------------------------
    // Response path
    // ----------------------------------------------------------------

    // A query loads data; a read hands it over; a new command drops it
    always_comb begin
        next_rspPending = rspPending;
        next_rspData    = rspData;
        next_rspStrobe  = 1'b0;
        if (readReq && rspPending) begin
            next_rspStrobe  = 1'b1;
            next_rspPending = 1'b0;
        end
        if (cmdValid) begin
            next_rspPending = 1'b0; // Unread data discarded
        end
        if (link.dec.esrQuery) begin
            next_rspData    = {8'h00, eventLatch};
            next_rspPending = 1'b1;
        end
        if (link.dec.maskQuery) begin
            next_rspData    = {8'h00, eventMask};
            next_rspPending = 1'b1;
        end
        if (link.dec.condQuery) begin
            next_rspData    = link.cond;
            next_rspPending = 1'b1;
        end
        if (link.dec.evtQuery) begin
            next_rspData    = link.evt;
            next_rspPending = 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rspPending <= 1'b0;
            rspStrobe  <= 1'b0;
            rspData    <= 16'h0000;
        end else begin
            rspPending <= next_rspPending;
            rspStrobe  <= next_rspStrobe;
            rspData    <= next_rspData;
        end
    end

    // ----------------------------------------------------------------
    // Error queue push
    // ----------------------------------------------------------------

    // One push per cycle: command error, then execution, then device
    always_comb begin
        next_errPush    = 1'b0;
        next_errCode    = 16'h0000;
        next_resetPulse = link.dec.reset | link.dec.preset;
        if (link.dec.illegal) begin
            next_errPush = 1'b1;
            next_errCode = `ISR_CODE_CMD_ERR;
        end else if (execFault) begin
            next_errPush = 1'b1;
            next_errCode = execCode;
        end else if (deviceFault) begin
            next_errPush = 1'b1;
            next_errCode = deviceCode;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            errPush    <= 1'b0;
            errCode    <= 16'h0000;
            resetPulse <= 1'b0;
        end else begin
            errPush    <= next_errPush;
            errCode    <= next_errCode;
            resetPulse <= next_resetPulse;
        end
    end
endmodule

// [tb/isr_status_chk.sv]
`timescale 1ns/1ps
`include "isr_regs.svh"
// ----------------------------------------
// Port checker
// ----------------------------------------
module isr_status_chk (
    // Clock and reset
    input wire logic        core_clk,
    input wire logic        resetn,
    // Command and response
    input wire logic        cmdValid,
    input wire logic [3:0]  cmdOp,
    input wire logic        readReq,
    input wire logic        rspPending,
    input wire logic        rspStrobe,
    input wire logic [15:0] rspData,
    // Events and error queue
    input wire logic        execFault,
    input wire logic [15:0] execCode,
    input wire logic        errPush,
    input wire logic [15:0] errCode,
    input wire logic        resetPulse
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    logic ill;
    // Command codes outside the decoded set
    assign ill = cmdValid && (cmdOp == 4'h0 || cmdOp > 4'h9);

    chk_query_pend: assert property (cmdValid && cmdOp == `ISR_CMD_ESR_QUERY |=> rspPending)
        else $error("no response after query");
    chk_read_strobe: assert property (readReq && rspPending && !cmdValid |=> rspStrobe && !rspPending)
        else $error("read not answered");
    chk_strobe_cause: assert property (rspStrobe |-> $past(readReq && rspPending))
        else $error("strobe without read");
    chk_orphan_read: assert property (readReq && !rspPending |=> !rspStrobe)
        else $error("orphan read answered");
    chk_byte_unused: assert property (cmdValid && (cmdOp == `ISR_CMD_ESR_QUERY ||
        cmdOp == `ISR_CMD_MASK_QUERY) |=> rspData[15:8] == 8'h00 && !rspData[1])
        else $error("unused event bit set");
    chk_op_unused: assert property (cmdValid && (cmdOp == `ISR_CMD_COND_QUERY ||
        cmdOp == `ISR_CMD_EVT_QUERY) |=> (rspData & ~`ISR_OP_USED_MASK) == 16'h0000)
        else $error("unused operation bit set");
    chk_cmd_err: assert property (ill |=> errPush && errCode == `ISR_CODE_CMD_ERR)
        else $error("command error not queued");
    chk_exec_push: assert property (execFault && !ill |=> errPush && errCode == $past(execCode))
        else $error("execution error not queued");
    chk_reset_pulse: assert property (cmdValid && (cmdOp == `ISR_CMD_RESET ||
        cmdOp == `ISR_CMD_PRESET) |=> resetPulse)
        else $error("no reset pulse");

    cov_read: cover property (readReq && rspPending);
    cov_cmd_err: cover property (ill);
    cov_reset: cover property (resetPulse);
endmodule

bind isr_status_event_regs isr_status_chk isr_status_chk_i (.core_clk, .resetn, .cmdValid, .cmdOp,
    .readReq, .rspPending, .rspStrobe, .rspData, .execFault, .execCode, .errPush, .errCode,
    .resetPulse);

// [tb/isr_ctrl_model.sv]
`timescale 1ns/1ps
// ----------------------------------------
// Remote controller model
// ----------------------------------------
module isr_ctrl_model (
    // Clock
    input wire logic        core_clk,
    // Command port
    output logic            cmdValid,
    output logic [3:0]      cmdOp,
    output logic [7:0]      cmdData,
    output logic            readReq,
    // Response
    input wire logic        rspPending,
    input wire logic        rspStrobe,
    input wire logic [15:0] rspData
);
    // Idle values
    initial begin
        cmdValid = 1'b0;
        cmdOp = 4'hF;
        cmdData = 8'h5A;
        readReq = 1'b0;
    end

    // One command for one cycle; idle fields scrambled afterwards
    task automatic send(input logic [3:0] op, input logic [7:0] data);
        @(negedge core_clk);
        cmdValid = 1'b1;
        cmdOp = op;
        cmdData = data;
        @(negedge core_clk);
        cmdValid = 1'b0;
        cmdOp = ~op;
        cmdData = ~data;
    endtask

    // Query, then fetch the answer by a read request
    task automatic ask(input logic [3:0] op, output logic [15:0] rsp);
        int n;
        rsp = 16'hXXXX;
        send(op, 8'h00);
        n = 0;
        while (rspPending !== 1'b1 && n < 8) begin
            @(negedge core_clk);
            n++;
        end
        readReq = 1'b1;
        @(negedge core_clk);
        readReq = 1'b0;
        n = 0;
        while (rspStrobe !== 1'b1 && n < 8) begin
            @(negedge core_clk);
            n++;
        end
        if (rspStrobe === 1'b1) begin
            rsp = rspData;
        end
    endtask

    // Read request with nothing asked
    task automatic orphan();
        @(negedge core_clk);
        readReq = 1'b1;
        @(negedge core_clk);
        readReq = 1'b0;
    endtask
endmodule

// [tb/isr_status_event_regs_bench.sv]
`timescale 1ns/1ps
`include "isr_regs.svh"
module isr_status_event_regs_bench;
    logic core_clk, resetn, execBusy, deviceFault, execFault, manualSwitch;
    logic calibrating, measuring, waitTrigger, belowLimit, aboveLimit, sensorConnect, initDone;
    logic cmdValid, readReq, rspPending, rspStrobe, errPush, eventSummary, resetPulse;
    logic [3:0] cmdOp;
    logic [7:0] cmdData;
    logic [15:0] rspData, deviceCode, execCode, errCode, r;
    int nErrors = 0;
    int checks = 0;

    isr_status_event_regs isr_status_event_regs_i (.core_clk, .resetn, .cmdValid, .cmdOp,
        .cmdData, .readReq, .rspPending, .rspStrobe, .rspData, .execBusy, .deviceFault,
        .deviceCode, .execFault, .execCode, .manualSwitch, .calibrating, .measuring,
        .waitTrigger, .belowLimit, .aboveLimit, .sensorConnect, .initDone, .errPush,
        .errCode, .eventSummary, .resetPulse);
    isr_ctrl_model isr_ctrl_model_i (.core_clk, .cmdValid, .cmdOp, .cmdData, .readReq,
        .rspPending, .rspStrobe, .rspData);

    // Clock
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            nErrors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic results();
        $display("Checks %0d errors %0d", checks, nErrors);
        if (nErrors == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Wait for an error queue push and compare its code
    task automatic push(input logic [15:0] code);
        int n;
        n = 0;
        while (errPush !== 1'b1 && n < 4) begin
            @(negedge core_clk);
            n++;
        end
        chk({15'h0000, errPush}, 16'h0001);
        chk(errCode, code);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_power_on();
        isr_ctrl_model_i.ask(`ISR_CMD_ESR_QUERY, r);
        chk(r, 16'h0080);
        isr_ctrl_model_i.ask(`ISR_CMD_COND_QUERY, r);
        chk(r, 16'h0400);
        isr_ctrl_model_i.ask(`ISR_CMD_ESR_QUERY, r);
        chk(r, 16'h0000);
        isr_ctrl_model_i.send(`ISR_CMD_MASK_WRITE, 8'hFF);
        isr_ctrl_model_i.ask(`ISR_CMD_MASK_QUERY, r);
        chk(r, 16'h00FD);
    endtask

    task automatic t_opc();
        execBusy = 1'b1;
        isr_ctrl_model_i.send(`ISR_CMD_OPC, 8'h00);
        repeat (3) @(negedge core_clk);
        chk({15'h0000, eventSummary}, 16'h0000);
        execBusy = 1'b0;
        repeat (3) @(negedge core_clk);
        chk({15'h0000, eventSummary}, 16'h0001);
        isr_ctrl_model_i.ask(`ISR_CMD_ESR_QUERY, r);
        chk(r, 16'h0001);
        // Nothing busy: completion is flagged at once
        isr_ctrl_model_i.send(`ISR_CMD_OPC, 8'h00);
        isr_ctrl_model_i.ask(`ISR_CMD_ESR_QUERY, r);
        chk(r, 16'h0001);
    endtask

    task automatic t_errors();
        @(negedge core_clk);
        deviceFault = 1'b1;
        deviceCode = 16'hFEA2;
        @(negedge core_clk);
        deviceFault = 1'b0;
        push(16'hFEA2);
        @(negedge core_clk);
        execFault = 1'b1;
        execCode = 16'hFF06;
        @(negedge core_clk);
        execFault = 1'b0;
        push(16'hFF06);
        for (int i = 10; i <= 16; i++) begin
            isr_ctrl_model_i.send(4'(i), 8'h00);
            push(`ISR_CODE_CMD_ERR);
        end
        // A known command queues nothing
        isr_ctrl_model_i.send(`ISR_CMD_OTHER, 8'h00);
        chk({15'h0000, errPush}, 16'h0000);
        @(negedge core_clk);
        manualSwitch = 1'b1;
        @(negedge core_clk);
        manualSwitch = 1'b0;
        isr_ctrl_model_i.ask(`ISR_CMD_ESR_QUERY, r);
        chk(r, 16'h0078);
    endtask

    task automatic t_query_err();
        isr_ctrl_model_i.orphan();
        isr_ctrl_model_i.ask(`ISR_CMD_ESR_QUERY, r);
        chk(r, 16'h0004);
        isr_ctrl_model_i.send(`ISR_CMD_COND_QUERY, 8'h00);
        isr_ctrl_model_i.ask(`ISR_CMD_ESR_QUERY, r);
        chk(r, 16'h0000);
        isr_ctrl_model_i.ask(`ISR_CMD_ESR_QUERY, r);
        chk(r, 16'h0004);
        isr_ctrl_model_i.ask(`ISR_CMD_ESR_QUERY, r);
        chk(r, 16'h0000);
    endtask

    task automatic t_oper();
        // End the initialization left running, then empty the event part
        @(negedge core_clk);
        initDone = 1'b1;
        @(negedge core_clk);
        initDone = 1'b0;
        isr_ctrl_model_i.ask(`ISR_CMD_EVT_QUERY, r);
        chk(r, 16'h0400);
        {calibrating, measuring, waitTrigger, belowLimit, aboveLimit} = 5'h1F;
        repeat (2) @(negedge core_clk);
        isr_ctrl_model_i.ask(`ISR_CMD_COND_QUERY, r);
        chk(r, 16'h1831);
        isr_ctrl_model_i.ask(`ISR_CMD_EVT_QUERY, r);
        chk(r, 16'h1831);
        isr_ctrl_model_i.ask(`ISR_CMD_EVT_QUERY, r);
        chk(r, 16'h0000);
        // Drop measuring and the lower limit only, so each bit is told apart
        {calibrating, measuring, waitTrigger, belowLimit, aboveLimit} = 5'h15;
        repeat (2) @(negedge core_clk);
        isr_ctrl_model_i.ask(`ISR_CMD_EVT_QUERY, r);
        chk(r, 16'h0810);
        isr_ctrl_model_i.ask(`ISR_CMD_COND_QUERY, r);
        chk(r, 16'h1021);
    endtask

    // Connect, reset and preset each start initialization
    task automatic t_init();
        for (int k = 0; k < 3; k++) begin
            @(negedge core_clk);
            initDone = 1'b1;
            @(negedge core_clk);
            initDone = 1'b0;
            isr_ctrl_model_i.ask(`ISR_CMD_COND_QUERY, r);
            chk(r, 16'h0000);
            if (k == 0) begin
                sensorConnect = 1'b1;
                @(negedge core_clk);
                sensorConnect = 1'b0;
            end else begin
                isr_ctrl_model_i.send(k == 1 ? `ISR_CMD_RESET : `ISR_CMD_PRESET, 8'h00);
            end
            repeat (2) @(negedge core_clk);
            isr_ctrl_model_i.ask(`ISR_CMD_COND_QUERY, r);
            chk(r, 16'h0400);
        end
    endtask

    // Watchdog
    initial begin
        repeat (5000) @(posedge core_clk);
        nErrors++;
        results();
    end

    // Main sequence
    initial begin
        resetn = 1'b0;
        {execBusy, deviceFault, execFault, manualSwitch, sensorConnect, initDone} = 6'h00;
        {calibrating, measuring, waitTrigger, belowLimit, aboveLimit} = 5'h00;
        deviceCode = 16'h0000;
        execCode = 16'h0000;
        repeat (8) @(posedge core_clk);
        @(negedge core_clk);
        resetn = 1'b1;
        t_power_on();
        t_opc();
        t_errors();
        t_query_err();
        t_init();
        t_oper();
        results();
    end
endmodule
